// File: hdl/fac_consts.svh
`ifndef FAC_CONSTS_SVH
`define FAC_CONSTS_SVH

// register addresses
`define FAC_ADDR_FLASH_CTRL 16'hFE08
`define FAC_ADDR_BLOCK_PROTECT 16'hFFBE
`define FAC_ADDR_OSC_TRIM 16'hFFC0
`define FAC_ADDR_WATCHDOG 16'hFFFF

// control register layout and reset value
`define FAC_CTRL_RESET 4'h0
`define FAC_CTRL_UPPER 4'h0

// array values
`define FAC_ERASED_BYTE 8'hFF
`define FAC_NONE_PROTECTED 8'hFF
`define FAC_READ_ZERO 8'h00

// geometry: address bits below a page and below a row
`define FAC_PAGE_BITS 6
`define FAC_ROW_BITS 5

`endif

// File: hdl/fac_flash_array_control.sv
`include "fac_consts.svh"

module fac_flash_array_control
  import fac_pkg::*;
#(
  parameter int FLASH_BYTES = 4096,
  parameter int WDT_CYCLES = 262144
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire fac_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // mode and security
  input wire logic monitor_mode,
  input wire logic security_engaged,
  input wire logic test_voltage,
  // status
  output logic charge_pump_on,
  output logic erase_busy,
  output logic [7:0] osc_trim,
  output logic watchdog_timeout
);

  localparam int AW = $clog2(FLASH_BYTES);
  localparam logic [16:0] TOP = 17'h10000;
  localparam logic [15:0] FLASH_BASE =
    16'(TOP - 17'(FLASH_BYTES));
  localparam logic [AW-1:0] LAST_IDX = '1;

  generate
    if (FLASH_BYTES < 256 || FLASH_BYTES > 32768 ||
        (FLASH_BYTES & (FLASH_BYTES - 1)) != 0) begin : g_bad
      $error("flash size must be a power of two, 256 to 32768");
    end
  endgenerate

  // address decoding shared by several processes
  // the control register sits inside the array's address range; its
  // address belongs to the register, so a control write never counts
  // as the latching array write and never lands in the array
  function automatic logic in_flash(input logic [15:0] a);
    in_flash = a >= FLASH_BASE &&
               a != `FAC_ADDR_FLASH_CTRL;
  endfunction

  function automatic logic [AW-1:0] idx(input logic [15:0] a);
    idx = a[AW-1:0];
  endfunction

  // protected range runs from the bound upward to the top of the array;
  // the protect location itself also needs the external test voltage
  function automatic logic is_protected(input logic [15:0] a,
                                        input logic [7:0] bound,
                                        input logic tv);
    logic prot;
    prot = bound != `FAC_NONE_PROTECTED && a[15:8] >= bound;
    if (a == `FAC_ADDR_BLOCK_PROTECT) begin
      prot = prot || !tv;
    end
    is_protected = prot;
  endfunction

  // array storage, nonvolatile so it is not touched by reset; it starts
  // erased for simulation, as parts leave the factory erased
  logic [7:0] mem [FLASH_BYTES] = '{default: `FAC_ERASED_BYTE};

  fac_ctrl_t ctrl_reg;
  fac_ctrl_t ctrl_next;
  fac_ctrl_t ctrl_wdata;
  logic pgm_next;
  logic erase_next;
  logic mass_next;
  fac_seq_t seq_reg;
  logic [15:0] latch_addr_reg;
  logic [AW-1:0] erase_ptr_reg;
  logic [AW-1:0] erase_end_reg;
  logic erase_busy_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] osc_trim_reg;
  logic [7:0] protect_bound;
  logic ctrl_wr;
  logic flash_wr;
  logic flash_rd;
  logic high_voltage_enable_ok;
  logic erase_start;
  logic prog_wr;
  logic same_row;
  logic wdt_clear;
  logic view_blocked;

  // decode of the register port
  assign ctrl_wr = bus_req.wr && bus_req.addr == `FAC_ADDR_FLASH_CTRL;
  assign flash_wr = bus_req.wr && in_flash(bus_req.addr);
  assign flash_rd = bus_req.rd && in_flash(bus_req.addr);
  assign ctrl_wdata = fac_ctrl_t'(bus_req.wdata[3:0]);
  assign wdt_clear = bus_req.wr &&
                     bus_req.addr == `FAC_ADDR_WATCHDOG;

  // protect bound lives in the array itself
  assign protect_bound = mem[idx(`FAC_ADDR_BLOCK_PROTECT)];

  // readers that are not the processor see no array data while secured; the control register still reads back
  assign view_blocked = monitor_mode && security_engaged;

  // select bits after a control write; kept apart from the high
  // voltage bit so that the gate below reads settled selects and no
  // combinational path runs from the gate back into its own inputs
  always_comb begin
    pgm_next = ctrl_reg.program_select;
    erase_next = ctrl_reg.erase;
    mass_next = ctrl_reg.mass;
    if (ctrl_wr) begin
      mass_next = ctrl_wdata.mass;
      // a write asking for both selects changes neither, and a select
      // cannot be taken while the other one is still held
      if (!(ctrl_wdata.program_select && ctrl_wdata.erase)) begin
        pgm_next = ctrl_wdata.program_select && !ctrl_reg.erase;
        erase_next = ctrl_wdata.erase && !ctrl_reg.program_select;
      end
    end
  end

  // high voltage gate: a select is on, protect was read, an address
  // was latched, and that address may be altered
  always_comb begin
    high_voltage_enable_ok = (pgm_next || erase_next) &&
              seq_reg == FAC_SQ_READY;
    if (is_protected(latch_addr_reg, protect_bound, test_voltage)) begin
      high_voltage_enable_ok = 1'b0;
    end
    if (erase_next && mass_next &&
        protect_bound != `FAC_NONE_PROTECTED) begin
      high_voltage_enable_ok = 1'b0;
    end
  end

  // control register write; high voltage sets only through the gate
  // and drops on any control write that leaves its bit clear
  always_comb begin
    ctrl_next.program_select = pgm_next;
    ctrl_next.erase = erase_next;
    ctrl_next.mass = mass_next;
    ctrl_next.high_voltage_enable = ctrl_reg.high_voltage_enable;
    if (ctrl_wr) begin
      ctrl_next.high_voltage_enable = 1'b0;
      if (ctrl_wdata.high_voltage_enable) begin
        ctrl_next.high_voltage_enable = ctrl_reg.high_voltage_enable || high_voltage_enable_ok;
      end
    end
  end

  // control register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= fac_ctrl_t'(`FAC_CTRL_RESET);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // preparation sequence; leaving both selects clear starts it over
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seq_reg <= FAC_SQ_IDLE;
    end else if (!ctrl_next.program_select && !ctrl_next.erase) begin
      seq_reg <= FAC_SQ_IDLE;
    end else begin
      case (seq_reg)
        FAC_SQ_IDLE: begin
          seq_reg <= FAC_SQ_PROTECT_READ;
        end
        FAC_SQ_PROTECT_READ: begin
          if (bus_req.rd &&
              bus_req.addr == `FAC_ADDR_BLOCK_PROTECT) begin
            seq_reg <= FAC_SQ_LATCH;
          end
        end
        FAC_SQ_LATCH: begin
          if (flash_wr) begin
            seq_reg <= FAC_SQ_READY;
          end
        end
        FAC_SQ_READY: begin
          seq_reg <= FAC_SQ_READY;
        end
        default: begin
          seq_reg <= FAC_SQ_IDLE;
        end
      endcase
    end
  end

  // the latching write picks the row or page to be worked on;
  // its data is discarded
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latch_addr_reg <= FLASH_BASE;
    end else if (seq_reg == FAC_SQ_LATCH && flash_wr) begin
      latch_addr_reg <= bus_req.addr;
    end
  end

  // erase starts on the rising of high voltage with erase selected;
  // dropping high voltage later does not stop a walk already running
  assign erase_start = !ctrl_reg.high_voltage_enable && ctrl_next.high_voltage_enable &&
                       ctrl_next.erase;

  // erase walker writes the erased value one byte per clock; a page
  // takes 64 clocks, the whole array one clock per byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      erase_busy_reg <= 1'b0;
      erase_ptr_reg <= '0;
      erase_end_reg <= '0;
    end else if (erase_start) begin
      erase_busy_reg <= 1'b1;
      if (ctrl_next.mass) begin
        erase_ptr_reg <= '0;
        erase_end_reg <= LAST_IDX;
      end else begin
        erase_ptr_reg <= {latch_addr_reg[AW-1:`FAC_PAGE_BITS],
                          {`FAC_PAGE_BITS{1'b0}}};
        erase_end_reg <= {latch_addr_reg[AW-1:`FAC_PAGE_BITS],
                          {`FAC_PAGE_BITS{1'b1}}};
      end
    end else if (erase_busy_reg) begin
      erase_ptr_reg <= erase_ptr_reg + 1'b1;
      if (erase_ptr_reg == erase_end_reg) begin
        erase_busy_reg <= 1'b0;
      end
    end
  end

  // programming writes only inside the latched row
  assign same_row = bus_req.addr[15:`FAC_ROW_BITS] ==
                    latch_addr_reg[15:`FAC_ROW_BITS];

  // any path may drive this, monitor or application code alike; the
  // row and protect checks repeat here so a stray write cannot land
  assign prog_wr = flash_wr && ctrl_reg.high_voltage_enable && ctrl_reg.program_select &&
                   seq_reg == FAC_SQ_READY && same_row &&
                   !is_protected(bus_req.addr, protect_bound,
                                 test_voltage);

  // array write port; programming can only pull bits to zero, so a
  // second program of the same byte cannot raise any bit again
  always_ff @(posedge clk) begin
    if (erase_busy_reg) begin
      mem[erase_ptr_reg] <= `FAC_ERASED_BYTE;
    end else if (prog_wr) begin
      mem[idx(bus_req.addr)] <=
        mem[idx(bus_req.addr)] & bus_req.wdata;
    end
  end

  // read data stands for the one cycle after the read strobe; a read
  // during an erase sees the array part way through the walk
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_reg <= `FAC_READ_ZERO;
    end else if (bus_req.rd &&
                 bus_req.addr == `FAC_ADDR_FLASH_CTRL) begin
      rd_data_reg <= {`FAC_CTRL_UPPER, ctrl_reg};
    end else if (flash_rd && view_blocked) begin
      rd_data_reg <= `FAC_READ_ZERO;
    end else if (flash_rd) begin
      // the watchdog address reads back the reset vector low byte
      rd_data_reg <= mem[idx(bus_req.addr)];
    end else begin
      rd_data_reg <= `FAC_READ_ZERO;
    end
  end

  // trim value mirrored out of the array for the oscillator
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      osc_trim_reg <= `FAC_ERASED_BYTE;
    end else begin
      osc_trim_reg <= mem[idx(`FAC_ADDR_OSC_TRIM)];
    end
  end

  // watchdog counter serviced by writes to its address; such a write
  // is an array write too, so avoid it while high voltage is on
  fac_watchdog #(
    .CYCLES(WDT_CYCLES)
  ) u_watchdog (
    .clk(clk),
    .reset_n(reset_n),
    .clear(wdt_clear),
    .timeout(watchdog_timeout)
  );

  // outputs straight from flip-flops
  assign rd_data = rd_data_reg;
  assign charge_pump_on = ctrl_reg.high_voltage_enable;
  assign erase_busy = erase_busy_reg;
  assign osc_trim = osc_trim_reg;

endmodule

// File: hdl/fac_pkg.sv
package fac_pkg;

  // flash control register, bit 3 down to bit 0
  typedef struct packed {
    logic high_voltage_enable;
    logic mass;
    logic erase;
    logic program_select;
  } fac_ctrl_t;

  // one register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fac_bus_req_t;

  // preparation steps before high voltage may be enabled
  typedef enum logic [1:0] {
    FAC_SQ_IDLE,
    FAC_SQ_PROTECT_READ,
    FAC_SQ_LATCH,
    FAC_SQ_READY
  } fac_seq_t;

endpackage

// File: hdl/fac_watchdog.sv
module fac_watchdog
  import fac_pkg::*;
#(
  parameter int CYCLES = 262144
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // service and expiry
  input wire logic clear,
  output logic timeout
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_reg;
  logic timeout_reg;

  generate
    if (CYCLES < 2) begin : g_bad
      $error("watchdog period too short");
    end
  endgenerate

  // counter restarts on service or on expiry
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else if (clear || count_reg == LAST) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // one-cycle expiry pulse, suppressed by a same-cycle service
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= !clear && count_reg == LAST;
    end
  end

  assign timeout = timeout_reg;

endmodule

// File: verif/fac_flash_monitor.sv
`include "fac_consts.svh"
module fac_flash_monitor
  import fac_pkg::*;
#(
  parameter int FLASH_BYTES = 4096,
  parameter int WDT_CYCLES = 262144
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire fac_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  // mode inputs
  input wire logic monitor_mode,
  input wire logic security_engaged,
  input wire logic test_voltage,
  // status
  input wire logic charge_pump_on,
  input wire logic erase_busy,
  input wire logic [7:0] osc_trim,
  input wire logic watchdog_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BASE = 65536 - FLASH_BYTES;
  logic [15:0] busy_cnt;
  logic ctrl_wr;
  logic ctrl_rd;
  logic high_voltage_enable_wr;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // decode of control register accesses
  assign ctrl_wr = bus_req.wr && bus_req.addr == `FAC_ADDR_FLASH_CTRL;
  assign ctrl_rd = bus_req.rd && bus_req.addr == `FAC_ADDR_FLASH_CTRL;
  assign high_voltage_enable_wr = ctrl_wr && bus_req.wdata[3];
  // length of the running erase, zero while idle
  always_ff @(posedge clk) begin
    if (!reset_n || !erase_busy) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= busy_cnt + 16'h0001;
    end
  end
  a_read_idle: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside a read");
  a_ctrl_readback: assert property (ctrl_rd |=> rd_data[7:4] == 4'h0
    && rd_data[3] == charge_pump_on)
    else $error("control readback wrong");
  a_pump_cause: assert property ($rose(charge_pump_on)
    |-> $past(high_voltage_enable_wr))
    else $error("charge pump on without enable write");
  a_pump_clear: assert property (ctrl_wr && !bus_req.wdata[3]
    |=> !charge_pump_on)
    else $error("charge pump stays on after clear");
  a_erase_pump: assert property ($rose(erase_busy) |-> charge_pump_on)
    else $error("erase without charge pump");
  a_erase_length: assert property ($fell(erase_busy)
    |-> busy_cnt == 16'h0040 || busy_cnt == FLASH_BYTES)
    else $error("erase length wrong");
  a_wdog_pulse: assert property (watchdog_timeout |=> !watchdog_timeout)
    else $error("timeout longer than one cycle");
  a_wdog_service: assert property (bus_req.wr && bus_req.addr ==
    `FAC_ADDR_WATCHDOG |=> ##1 !watchdog_timeout [*7])
    else $error("timeout soon after service");
  a_unmapped_read: assert property (bus_req.rd
    && int'(bus_req.addr) < BASE |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_select_excl: assert property (ctrl_rd
    |=> !(rd_data[1] && rd_data[0]))
    else $error("program and erase both set");
  a_secure_read: assert property (bus_req.rd && monitor_mode
    && security_engaged && int'(bus_req.addr) >= BASE && !ctrl_rd
    |=> rd_data == 8'h00)
    else $error("secured array visible");
endmodule

// File: verif/tb_fac_flash_array_control.sv
module tb_fac_flash_array_control
  import fac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  fac_bus_req_t bus_req = '0;
  logic monitor_mode = 1'b0;
  logic security_engaged = 1'b0;
  logic test_voltage = 1'b0;
  logic [7:0] rd_data, osc_trim, last_rd;
  logic charge_pump_on, erase_busy, watchdog_timeout;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  fac_flash_array_control #(.FLASH_BYTES(4096), .WDT_CYCLES(16))
    fac_flash_array_control_i (.clk(clk), .reset_n(reset_n),
    .bus_req(bus_req), .rd_data(rd_data), .monitor_mode(monitor_mode),
    .security_engaged(security_engaged), .test_voltage(test_voltage),
    .charge_pump_on(charge_pump_on), .erase_busy(erase_busy),
    .osc_trim(osc_trim), .watchdog_timeout(watchdog_timeout));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one strobe cycle then one idle cycle, so no strobe is set twice at once
  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus_req <= '0;
    #1 last_rd = rd_data;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(a, d, 1'b1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string s);
    bus(a, 8'h00, 1'b0);
    chk(s, e, last_rd);
  endtask
  task automatic t_reset_values();
    rd(16'hFE08, 8'h00, "ctrl after reset");
    chk("osc trim", 8'hFF, osc_trim);
    rd(16'hF000, 8'hFF, "erased byte");
    rd(16'hFFFF, 8'hFF, "reset vector low");
    rd(16'h0100, 8'h00, "unmapped");
  endtask
  task automatic t_interlock();
    wr(16'hFE08, 8'h03);
    rd(16'hFE08, 8'h00, "both selects");
    wr(16'hFE08, 8'h01);
    wr(16'hFE08, 8'h02);
    // clearing program in the same write does not free erase
    rd(16'hFE08, 8'h00, "erase while program held");
    wr(16'hFE08, 8'h09);
    rd(16'hFE08, 8'h01, "enable without steps");
    wr(16'hFE08, 8'h00);
    wr(16'hFE08, 8'h08);
    rd(16'hFE08, 8'h00, "enable without select");
  endtask
  // prepare steps, then enable high voltage with the given select bits
  task automatic arm(input logic [7:0] sel, input logic [15:0] a,
                     input logic [7:0] pv, input logic pump);
    wr(16'hFE08, sel);
    rd(16'hFFBE, pv, "protect value");
    wr(a, 8'h00);
    wr(16'hFE08, sel | 8'h08);
    chk("pump", {7'h00, pump}, {7'h00, charge_pump_on});
  endtask
  task automatic t_program();
    arm(8'h01, 16'hF100, 8'hFF, 1'b1);
    wr(16'hF105, 8'h0F);
    wr(16'hF120, 8'h00);
    wr(16'hFE08, 8'h00);
    chk("pump off", 8'h00, {7'h00, charge_pump_on});
    rd(16'hF105, 8'h0F, "programmed byte");
    rd(16'hF120, 8'hFF, "outside row");
  endtask
  task automatic t_erase();
    int n;
    // busy rises at the edge taking the enabling write, one cycle
    // before arm returns, so that cycle is counted up front
    n = 1;
    arm(8'h02, 16'hF100, 8'hFF, 1'b1);
    for (int i = 0; i < 200; i++) begin
      #1;
      if (erase_busy === 1'b1) begin
        n++;
      end else if (n > 0) begin
        break;
      end
      @(posedge clk);
    end
    @(posedge clk);
    chk("erase cycles", 8'h40, n[7:0]);
    wr(16'hFE08, 8'h00);
    rd(16'hF105, 8'hFF, "erased page");
  endtask
  task automatic t_watchdog();
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1 seen = seen | watchdog_timeout;
    end
    chk("expiry", 8'h01, {7'h00, seen});
    @(posedge clk);
    wr(16'hFFFF, 8'h5A);
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1 seen = seen | watchdog_timeout;
    end
    chk("serviced", 8'h00, {7'h00, seen});
    @(posedge clk);
    rd(16'hFFFF, 8'hFF, "vector after service");
  endtask
  // the monitor host sees the array only while security is off
  task automatic t_security();
    monitor_mode <= 1'b1;
    security_engaged <= 1'b1;
    @(posedge clk);
    rd(16'hF000, 8'h00, "secured read");
    security_engaged <= 1'b0;
    rd(16'hF000, 8'hFF, "open monitor read");
    monitor_mode <= 1'b0;
  endtask
  // bound F8 guards F800 upward; altering it needs the test voltage
  task automatic t_protect();
    test_voltage <= 1'b1;
    arm(8'h01, 16'hFFBE, 8'hFF, 1'b1);
    wr(16'hFFBE, 8'hF8);
    wr(16'hFE08, 8'h00);
    test_voltage <= 1'b0;
    rd(16'hFFBE, 8'hF8, "protect bound");
    arm(8'h01, 16'hF900, 8'hF8, 1'b0);
    wr(16'hF905, 8'h00);
    wr(16'hFE08, 8'h00);
    rd(16'hF905, 8'hFF, "protected byte");
    arm(8'h01, 16'hF100, 8'hF8, 1'b1);
    wr(16'hFE08, 8'h00);
    arm(8'h06, 16'hF100, 8'hF8, 1'b0);
    chk("mass refused", 8'h00, {7'h00, erase_busy});
    wr(16'hFE08, 8'h00);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_values();
    t_interlock();
    t_program();
    t_erase();
    t_watchdog();
    t_security();
    t_protect();
    give_verdict();
  end
endmodule
bind fac_flash_array_control fac_flash_monitor #(
  .FLASH_BYTES(FLASH_BYTES), .WDT_CYCLES(WDT_CYCLES)) fac_flash_monitor_i (
  .clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
  .monitor_mode(monitor_mode), .security_engaged(security_engaged),
  .test_voltage(test_voltage), .charge_pump_on(charge_pump_on),
  .erase_busy(erase_busy), .osc_trim(osc_trim),
  .watchdog_timeout(watchdog_timeout));
